// *** design/srp_port.v ***
// serial register port: command decode, shift engine, checksum and write queue
`timescale 1ns/1ps
`include "srp_regs.vh"
// ------------------------------------------------------------
// overview
// ------------------------------------------------------------
// the port sits between the serial pins and the register store.
// every pin is sampled by the system clock through two flip-flops,
// so the serial clock must stay slow next to i_clk: each serial
// half period has to span at least four system clocks, or an edge
// of the serial clock could be missed.
//
// a transfer always opens with a command byte. bit 7 picks the
// direction, bits 5..0 the target register. bit 6 is ignored here.
// the host must not read the command byte back; nothing returns it.
//
// command byte timing:
// - the data pin is taken at each synced falling edge of the clock
// - after the eighth fall the address is latched and the width
//   lookup address is presented on o_lookup_addr
// - the width comes back combinationally on i_width_bytes
//
// write timing:
// - the width is loaded on the first cycle in the write state
// - each completed byte is pushed into the write queue with its
//   destination address and byte lane
// - the lane counts down from the most significant lane in use
// - the queue head is handed out as a one-cycle o_wr_valid pulse
// - a byte cut short by a rising select never reaches the queue
// - when the queue is full a completed byte is dropped; the host
//   spacing between bytes keeps this from happening in normal use
//
// read timing:
// - o_rd_req pulses one cycle after the eighth command fall
// - the register value must stand on i_rd_data by the end of the o_rd_req cycle
// - the whole value is captured in one go, so a store that
//   updates its register mid-read cannot tear the transfer
// - the value is shifted up so that its top used byte leaves first
// - each synced rising edge drives the next bit on o_dout
// - o_dout_oe rises with the first data bit and falls on the
//   falling edge of the last clock pulse
//
// checksum:
// - the count restarts with the first bit of every read
// - each bit driven adds into the count
// - reading the checksum address returns the count of the
//   previous read and starts a new count over that read
// - o_sum follows the internal count one cycle later
//
// select handling:
// - a falling select restarts the port in command mode
// - a rising select abandons any transfer and frees the output
// - while select is high every serial edge is ignored
//
// leftover state:
// - the byte counter is cleared at every restart and at the end
//   of each command byte, so a transfer cut short never leaves a
//   stale count for the next write to pick up
//
// limitations:
// - a width of zero on i_width_bytes ends a write after one byte
// - write bytes are not acknowledged back to the host; a full
//   queue loses the byte silently
// - the checksum address is fixed by the header constants
//
// hazards:
// - a select edge and a clock edge seen in the same cycle favour
//   the select edge; the clock edge is then lost on purpose
// - the edge detectors reset to the idle levels of their pins so
//   that no false edge follows reset
// - only the second synchroniser stage feeds any logic
//
// output registers:
// - every output of this module comes straight from a flip-flop
// - the write outputs are refilled only after the previous
//   pulse has ended, so each byte is offered exactly once
// ------------------------------------------------------------
module srp_port #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire i_clk,               // 40 mhz system clock
    input wire i_sys_rst,           // async reset, active high
    input wire i_sclk,              // serial clock pin
    input wire i_din,               // serial data in pin
    input wire i_cs_n,              // chip select pin, active low
    output reg o_dout,              // serial data out
    output reg o_dout_oe,           // data out enable, high while driving
    output reg [5:0] o_rd_addr,     // address of register being read
    output reg o_rd_req,            // pulse: register read capture
    input wire [23:0] i_rd_data,    // register value, valid with o_rd_req
    input wire [1:0] i_width_bytes, // byte width of register on o_lookup_addr
    output reg [5:0] o_lookup_addr, // address being looked up for width
    output reg o_wr_valid,          // write byte valid
    input wire i_wr_ready,          // register side accepts byte
    output reg [5:0] o_wr_addr,     // destination register
    output reg [1:0] o_wr_lane,     // byte lane, 2 = most significant
    output reg [7:0] o_wr_byte,     // byte to store
    output reg o_wr_full_n,         // queue has space, active low full
    output reg [5:0] o_sum          // checksum of last read
);
    localparam ST_CMD = 3'b001;
    localparam ST_WR = 3'b010;
    localparam ST_RD = 3'b100;

    reg sclk_m, sclk_s, sclk_d;
    reg din_m, din_s;
    reg cs_m, cs_s, cs_d;
    reg [2:0] state;
    reg [2:0] bit_cnt;
    reg [1:0] bytes_left;
    reg [7:0] shift_in;
    reg [23:0] shift_out;
    reg [5:0] addr;
    reg [5:0] sum;
    reg first_rise;
    reg last_fall;
    reg cap_pend;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire cs_rise;
    wire [7:0] byte_in;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [29:0] fifo_out_data;
    reg fifo_push;
    reg [29:0] fifo_push_data;
    wire [23:0] rd_value;

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sclk_m <= 1'b1;
            sclk_s <= 1'b1;
            sclk_d <= 1'b1;
            din_m <= 1'b0;
            din_s <= 1'b0;
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
        end else begin
            sclk_m <= i_sclk;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            din_m <= i_din;
            din_s <= din_m;
            cs_m <= i_cs_n;
            cs_s <= cs_m;
            cs_d <= cs_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;
    assign cs_fall = ~cs_s & cs_d;
    assign cs_rise = cs_s & ~cs_d;
    assign byte_in = {shift_in[6:0], din_s};

    // checksum register reads back its own value, else external data
    assign rd_value = (addr == `SRP_ADDR_SUM) ? {18'h00000, sum} : i_rd_data;

    // ------------------------------------------------------------
    // main serial engine
    // ------------------------------------------------------------
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_CMD;
            bit_cnt <= 3'h0;
            bytes_left <= 2'h0;
            shift_in <= 8'h00;
            shift_out <= 24'h000000;
            addr <= 6'h00;
            sum <= `SRP_SUM_RESET;
            first_rise <= 1'b0;
            last_fall <= 1'b0;
            cap_pend <= 1'b0;
            o_dout <= 1'b0;
            o_dout_oe <= 1'b0;
            o_rd_addr <= 6'h00;
            o_rd_req <= 1'b0;
            o_lookup_addr <= 6'h00;
            fifo_push <= 1'b0;
            fifo_push_data <= 30'h00000000;
        end else begin
            o_rd_req <= 1'b0;
            fifo_push <= 1'b0;
            if (cs_fall) begin
                // restart in command mode
                state <= ST_CMD;
                bit_cnt <= 3'h0;
                bytes_left <= 2'h0;
                cap_pend <= 1'b0;
                o_dout_oe <= 1'b0;
                last_fall <= 1'b0;
            end else if (cs_rise) begin
                // abandon transfer, partial byte discarded, output released
                state <= ST_CMD;
                bit_cnt <= 3'h0;
                bytes_left <= 2'h0;
                cap_pend <= 1'b0;
                o_dout_oe <= 1'b0;
                last_fall <= 1'b0;
            end else if (!cs_s) begin
                if (cap_pend) begin
                    // whole register captured at once after command byte
                    cap_pend <= 1'b0;
                    shift_out <= rd_value << ({3'h0, 2'd3 - i_width_bytes} * 5'd8);
                    bytes_left <= i_width_bytes;
                end
                case (state)
                    ST_CMD: begin
                        if (sclk_fall) begin
                            shift_in <= byte_in;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                addr <= byte_in[`SRP_CMD_ADDR_MSB:0];
                                bytes_left <= 2'h0; // no stale count from a cut transfer
                                o_lookup_addr <= byte_in[`SRP_CMD_ADDR_MSB:0];
                                if (byte_in[`SRP_CMD_DIR_BIT]) begin
                                    state <= ST_WR;
                                end else begin
                                    state <= ST_RD;
                                    o_rd_addr <= byte_in[`SRP_CMD_ADDR_MSB:0];
                                    o_rd_req <= 1'b1;
                                    cap_pend <= 1'b1;
                                    first_rise <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_WR: begin
                        if (bytes_left == 2'h0 && bit_cnt == 3'h0) begin
                            bytes_left <= i_width_bytes;
                        end
                        if (sclk_fall) begin
                            shift_in <= byte_in;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                // completed byte goes to queue; lane counts down msb first
                                fifo_push <= 1'b1;
                                fifo_push_data <= {addr, 6'h00, bytes_left - 2'h1, 6'h00,
                                    byte_in, 2'h0};
                                bytes_left <= bytes_left - 2'h1;
                                if (bytes_left <= 2'h1) begin
                                    state <= ST_CMD;
                                end
                            end
                        end
                    end
                    ST_RD: begin
                        if (sclk_rise) begin
                            o_dout <= shift_out[23];
                            o_dout_oe <= 1'b1;
                            shift_out <= {shift_out[22:0], 1'b0};
                            bit_cnt <= bit_cnt + 3'h1;
                            if (first_rise) begin
                                first_rise <= 1'b0;
                                sum <= {5'h00, shift_out[23]};
                            end else begin
                                sum <= sum + {5'h00, shift_out[23]};
                            end
                            if (bit_cnt == 3'h7 && bytes_left == 2'h1) begin
                                last_fall <= 1'b1;
                            end
                            if (bit_cnt == 3'h7) begin
                                bytes_left <= bytes_left - 2'h1;
                            end
                        end
                        if (sclk_fall && last_fall) begin
                            o_dout_oe <= 1'b0;
                            last_fall <= 1'b0;
                            state <= ST_CMD;
                        end
                    end
                    default: begin
                        state <= ST_CMD;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // write byte queue toward the register store
    // ------------------------------------------------------------
    srp_fifo #(
        .WIDTH(`SRP_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(fifo_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_push_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(i_wr_ready & ~o_wr_valid),
        .o_out_data(fifo_out_data)
    );

    // register the queue head onto the write outputs
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wr_valid <= 1'b0;
            o_wr_addr <= 6'h00;
            o_wr_lane <= 2'h0;
            o_wr_byte <= 8'h00;
            o_wr_full_n <= 1'b1;
            o_sum <= `SRP_SUM_RESET;
        end else begin
            o_wr_full_n <= fifo_in_ready;
            o_sum <= sum;
            if (o_wr_valid) begin
                o_wr_valid <= 1'b0;
            end else if (fifo_out_valid && i_wr_ready) begin
                o_wr_valid <= 1'b1;
                o_wr_addr <= fifo_out_data[29:24];
                o_wr_lane <= fifo_out_data[17:16];
                o_wr_byte <= fifo_out_data[9:2];
            end
        end
    end
endmodule

// *** design/srp_regs.vh ***
// register offsets, field layouts and fifo sizes of the serial register port
`ifndef SRP_REGS_VH
`define SRP_REGS_VH
`define SRP_CMD_DIR_BIT 7
`define SRP_CMD_ADDR_MSB 5
`define SRP_ADDR_SUM 6'h3e
`define SRP_SUM_RESET 6'h00
`define SRP_FIFO_DEPTH 16
`define SRP_FIFO_WIDTH 30
`endif

// *** design/srp_fifo.v ***
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module srp_fifo #(
    parameter WIDTH = 30,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_clk,              // system clock
    input wire i_sys_rst,          // async reset, active high
    input wire i_in_valid,         // write side valid
    output wire o_in_ready,        // write side ready (not full)
    input wire [WIDTH-1:0] i_in_data, // write side data
    output wire o_out_valid,       // read side valid (not empty)
    input wire i_out_ready,        // read side ready
    output wire [WIDTH-1:0] o_out_data // read side data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire full;
    wire empty;
    wire push;
    wire pop;

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign o_in_ready = ~full;
    assign o_out_valid = ~empty;
    assign push = i_in_valid & ~full;
    assign pop = i_out_ready & ~empty;
    assign o_out_data = mem[rd_ptr[AW-1:0]];

    // pointers
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // storage, no reset needed
    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= i_in_data;
        end
    end
endmodule

// *** sim/srp_port_properties.sv ***
// checker for the serial register port outputs
`timescale 1ns/1ps
module srp_port_properties (
    input wire i_clk,           // system clock
    input wire i_sys_rst,       // async reset
    input wire i_sclk,          // serial clock pin
    input wire i_cs_n,          // chip select, active low
    input wire o_dout,          // serial data out
    input wire o_dout_oe,       // data out enable
    input wire o_rd_req,        // read capture pulse
    input wire o_wr_valid,      // write byte valid
    input wire [1:0] o_wr_lane, // write byte lane
    input wire [5:0] o_sum      // read checksum
);
    // ----------------------------------------
    // serial clock history and properties
    // ----------------------------------------
    reg [5:0] sclk_hist;
    wire sclk_rose = |(sclk_hist[4:0] & ~sclk_hist[5:1]); // rise seen 1 to 5 clocks back
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // newest sample of the pin sits in bit 0
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sclk_hist <= 6'h3f;
        end else begin
            sclk_hist <= {sclk_hist[4:0], i_sclk};
        end
    end
    sequence oe_soon;
        ##[1:40] o_dout_oe;
    endsequence
    sequence cs_idle;
        i_cs_n [*8];
    endsequence
    rd_req_pulse_a: assert property (o_rd_req |=> !o_rd_req)
        else $error("read capture longer than one cycle");
    read_drive_a: assert property (o_rd_req |-> oe_soon)
        else $error("read data not driven after command");
    cs_release_a: assert property ($rose(i_cs_n) |-> ##[0:4] !o_dout_oe)
        else $error("output kept driving after select rose");
    dout_edge_a: assert property (o_dout_oe && $past(o_dout_oe) && $changed(o_dout) |-> sclk_rose)
        else $error("data out changed away from a rising clock");
    sum_step_a: assert property ($changed(o_sum) |-> o_sum == $past(o_sum) + 6'h01 || o_sum <= 6'h01)
        else $error("checksum moved by more than one bit");
    wr_lane_a: assert property (o_wr_valid |-> o_wr_lane != 2'h3)
        else $error("write byte lane out of range");
    cs_quiet_a: assert property (cs_idle |-> !o_rd_req && !o_dout_oe)
        else $error("port active while deselected");
    sum_hold_a: assert property (cs_idle |=> $stable(o_sum))
        else $error("checksum changed while deselected");
endmodule
bind srp_port srp_port_properties chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
    .o_rd_req(o_rd_req), .o_wr_valid(o_wr_valid), .o_wr_lane(o_wr_lane), .o_sum(o_sum));

// *** sim/srp_host.sv ***
// host model: serial bus master driving clock, data and select
`timescale 1ns/1ps
module srp_host (
    input wire i_clk,  // system clock, pacing only
    input wire i_dout, // device data out
    output reg o_sclk, // serial clock, idle high
    output reg o_din,  // serial data to device
    output reg o_cs_n  // chip select, active low
);
    // ----------------------------------------
    // bus pacing, 100 ns half period
    // ----------------------------------------
    initial begin
        o_sclk = 1'b1;
        o_din = 1'b0;
        o_cs_n = 1'b1;
    end
    task half;
        repeat (4) @(negedge i_clk);
    endtask
    // select or deselect; a released data line shows the inverse level
    task sel(input v);
        begin
            o_cs_n = v;
            if (v) o_din = ~o_din;
            half;
        end
    endtask
    // n bits msb first, device output sampled just before each fall
    task xfer(input [7:0] tx, input integer n, output [7:0] rx);
        integer i;
        begin
            rx = 8'h00;
            for (i = 7; i > 7 - n; i = i - 1) begin
                o_din = tx[i];
                half;
                rx = {rx[6:0], i_dout};
                o_sclk = 1'b0;
                half;
                o_sclk = 1'b1;
            end
            repeat (48) @(negedge i_clk); // byte spacing
        end
    endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the serial register port
`timescale 1ns/1ps
module testbench;
    reg i_clk = 1'b0;
    reg i_sys_rst = 1'b1;
    reg i_wr_ready = 1'b0;
    reg [23:0] i_rd_data = 24'h000000;
    reg stall = 1'b0;
    reg [5:0] sum_m = 6'h00;
    reg [5:0] a;
    reg [23:0] mem [0:63];
    reg [1:0] wid [0:63];
    reg [15:0] exp_q [$];
    integer fails = 0, samples_checked = 0, cycles = 0, k;
    wire i_sclk, i_din, i_cs_n, o_dout, o_dout_oe, o_rd_req, o_wr_valid, o_wr_full_n;
    wire [5:0] o_rd_addr, o_lookup_addr, o_wr_addr, o_sum;
    wire [1:0] o_wr_lane;
    wire [1:0] i_width_bytes = wid[o_lookup_addr]; // width lookup
    wire [7:0] o_wr_byte;
    srp_port DUT (.i_clk, .i_sys_rst, .i_sclk, .i_din, .i_cs_n, .o_dout, .o_dout_oe,
        .o_rd_addr, .o_rd_req, .i_rd_data, .i_width_bytes, .o_lookup_addr, .o_wr_valid,
        .i_wr_ready, .o_wr_addr, .o_wr_lane, .o_wr_byte, .o_wr_full_n, .o_sum);
    wire dout_line = o_dout_oe ? o_dout : ~o_dout; // released line shows the inverse
    srp_host host (.i_clk(i_clk), .i_dout(dout_line), .o_sclk(i_sclk), .o_din(i_din),
        .o_cs_n(i_cs_n));
    // ----------------------------------------
    // clock, register store and timeout
    // ----------------------------------------
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    always @(negedge i_clk) begin
        if (o_rd_req) i_rd_data <= mem[o_rd_addr];
        if (o_wr_valid) begin
            check({o_wr_addr, o_wr_lane, o_wr_byte}, exp_q.pop_front());
            mem[o_wr_addr][8*o_wr_lane +: 8] <= o_wr_byte;
        end
        i_wr_ready <= !stall && ($urandom % 4 != 0);
        cycles = cycles + 1;
        if (cycles == 40000) begin
            fails = fails + 1;
            complete_run;
        end
    end
    task check(input [31:0] seen, input [31:0] want);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== want) begin
                fails = fails + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task complete_run;
        begin
            if (fails == 0 && samples_checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // ----------------------------------------
    // transfers with their expected results
    // ----------------------------------------
    task wr_reg(input [5:0] ad);
        reg [7:0] rx, b;
        integer j;
        begin
            host.xfer({2'b10, ad}, 8, rx);
            for (j = wid[ad]; j > 0; j = j - 1) begin
                b = $urandom;
                if (exp_q.size() < 16) exp_q.push_back({ad, 2'(j - 1), b});
                host.xfer(b, 8, rx);
            end
        end
    endtask
    task rd_reg(input [5:0] ad);
        reg [7:0] rx;
        reg [23:0] e;
        integer j, ones;
        begin
            ones = 0;
            host.xfer({2'b00, ad}, 8, rx);
            e = (ad == 6'h3e) ? {18'h0, sum_m} : mem[ad];
            for (j = wid[ad]; j > 0; j = j - 1) begin
                host.xfer(8'h00, 8, rx);
                check(rx, e[8*j-8 +: 8]);
                ones = ones + $countones(e[8*j-8 +: 8]);
            end
            sum_m = ones;
            check(o_sum, sum_m);
            check(o_dout_oe, 0);
        end
    endtask
    initial begin
        reg [7:0] rx;
        void'($urandom(79831));
        for (k = 0; k < 64; k = k + 1) begin
            mem[k] = $urandom;
            wid[k] = (k < 6) ? 2'h3 : 2'(1 + $urandom % 3);
        end
        wid[62] = 2'h1;
        repeat (16) @(negedge i_clk);
        i_sys_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        check(o_dout_oe, 0);
        check(o_wr_full_n, 1);
        host.sel(0);
        host.xfer(8'h85, 8, rx);
        host.xfer(8'hff, 4, rx); // cut write byte
        host.sel(1);
        host.sel(0);
        host.xfer(8'h05, 8, rx);
        host.xfer(8'h00, 3, rx);
        host.sel(1);
        check(o_dout_oe, 0);
        for (k = 0; k < 8; k = k + 1) begin
            a = $urandom % 62;
            host.sel(0);
            wr_reg(a);
            while (exp_q.size() != 0) @(negedge i_clk);
            rd_reg(a);
            rd_reg(6'h3e);
            host.sel(1);
        end
        stall = 1'b1;
        for (k = 0; k < 6; k = k + 1) begin
            host.sel(0);
            wr_reg(k[5:0]);
            host.sel(1);
        end
        check(o_wr_full_n, 0);
        stall = 1'b0;
        repeat (300) @(negedge i_clk);
        check(exp_q.size(), 0);
        check(o_wr_full_n, 1);
        complete_run;
    end
endmodule
